// ==== plc_consts.svh ====
// constants of the power loss state controller
`ifndef PLC_CONSTS_SVH
`define PLC_CONSTS_SVH

// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define PLC_CLK_HZ 25000000
`define PLC_SOFTSTART_MS 10
`define PLC_SOFTSTART_CYC ((`PLC_CLK_HZ / 1000) * `PLC_SOFTSTART_MS)
`define PLC_TEST_PERIOD_S 240
`define PLC_TEST_PERIOD_CYC (64'(`PLC_TEST_PERIOD_S) * 64'(`PLC_CLK_HZ))

// ------------------------------------------------------------
// register offsets and fields
// ------------------------------------------------------------
`define PLC_REG_STATE 8'h00
`define PLC_REG_CTRL 8'h0A
`define PLC_CTRL_FORCE_OFF_BIT 0
`define PLC_CTRL_TEST_BIT 1
`define PLC_CTRL_RESET 8'h00

// ------------------------------------------------------------
// operating state codes
// ------------------------------------------------------------
`define PLC_CODE_HOLD 3'h0
`define PLC_CODE_SOFT 3'h1
`define PLC_CODE_NORMAL 3'h2
`define PLC_CODE_TEST 3'h3
`define PLC_CODE_SUPPLY 3'h4
`define PLC_CODE_WARN 3'h5
`define PLC_CODE_FULL 3'h6

// ------------------------------------------------------------
// enable high threshold in millivolts per code
// ------------------------------------------------------------
`define PLC_ENOV_OFF 3'h0
`define PLC_ENOV_MV_0 11'd0
`define PLC_ENOV_MV_1 11'd820
`define PLC_ENOV_MV_2 11'd920
`define PLC_ENOV_MV_3 11'd1000
`define PLC_ENOV_MV_4 11'd1080
`define PLC_ENOV_MV_5 11'd1160
`define PLC_ENOV_MV_6 11'd1240
`define PLC_ENOV_MV_7 11'd1320

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define PLC_STATUS_W 15
`define PLC_SYNC_W 24
`define PLC_STATUS_RESET 15'h0000

`endif

// ==== plc_pkg.sv ====
// types of the power loss state controller
`default_nettype none

package plc_pkg;

	// one-hot operating states
	typedef enum logic [6:0] {
		st_hold = 7'h01,
		st_soft = 7'h02,
		st_normal = 7'h04,
		st_test = 7'h08,
		st_supply = 7'h10,
		st_warn = 7'h20,
		st_full = 7'h40
	} plc_state_e;

	typedef logic [2:0] plc_code_t;

endpackage

`default_nettype wire

// ==== plc_alert.sv ====
// status change detection, masking and active-low alert
`include "plc_consts.svh"
`default_nettype none

module plc_alert #(
	parameter int N = `PLC_STATUS_W
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [N-1:0] status_in,
	input wire logic [N-1:0] alert_mask,
	input wire logic status_read,
	output logic [N-1:0] fault_status,
	output logic fault_alert_n
);

	logic [N-1:0] status_reg;
	logic [N-1:0] pending_reg;
	logic [N-1:0] pending_next;
	logic [N-1:0] change_set;
	logic alert_reg;

	// ------------------------------------------------------------
	// change detect and sticky pending bits
	// ------------------------------------------------------------
	// unmasked edges of any status bit set a pending bit
	assign change_set = (status_in ^ status_reg) & ~alert_mask;
	// a read drops only bits whose fault is gone; a new change wins
	assign pending_next = change_set | (status_read ? (pending_reg & status_in) : pending_reg);

	// status snapshot and pending flags
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			status_reg <= `PLC_STATUS_RESET;
			pending_reg <= `PLC_STATUS_RESET;
			alert_reg <= 1'b0;
		end else begin
			status_reg <= status_in;
			pending_reg <= pending_next;
			alert_reg <= |pending_next;
		end
	end

	assign fault_status = status_reg;
	assign fault_alert_n = ~alert_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	alert_on_change_a: assert property (@(posedge clk_sys) disable iff (reset)
		(|change_set) |=> !fault_alert_n)
		else $error("unmasked status change did not assert alert");

	alert_held_fault_a: assert property (@(posedge clk_sys) disable iff (reset)
		(!fault_alert_n && status_read && |(pending_reg & status_in)) |=> !fault_alert_n)
		else $error("alert released while read fault still present");

	alert_release_a: assert property (@(posedge clk_sys) disable iff (reset)
		(!fault_alert_n && !status_read && ~|change_set) |=> !fault_alert_n)
		else $error("alert released without a status read");

endmodule

`default_nettype wire

// ==== plc_ctrl.sv ====
// power loss state controller: state machine, function enables, alert, i2c restart
// Function
// - seven states: hold, soft-start, normal, test, backup, warning off, full off.
// - power-up enters hold; backup goes hold on low enable, storage, buck fault.
// - writing one to control bit 0 forces the hold state.
// - settings reset only at power-up, kept on later hold entries.
// - hold leaves for soft-start when enable above low and supply above lockout.
// - soft-start ends after small drop and the 10 ms timer.
// - normal keeps switch on and charges the storage capacitors.
// - normal starts a capacitor test every four minutes.
// - control bit 1 starts a test; cleared when the test finishes.
// - a supply fault during the test goes straight to backup.
// - five supply faults enter backup: switch open, buck on.
// - thermal warning, regulator or boot fault enters warning off, boost off.
// - warning off goes full off at 155C, back to normal when clear.
// - full off disables everything; back to soft-start when cool, no overcurrent.
// - present state readable in register 0x00.
// - function enables follow the state table.
// - threshold code 000 disables high detection, others select fixed voltages.
// - any unmasked status change asserts the alert; each is maskable.
// - host reads status before release; alert stays if fault persists.
// - alert sources: supply, thermal, switch, storage, backup, buck, reference, monitor.
// - settings are volatile; read-only outputs report status.
// - any start condition restarts packet parsing; no timeout.
`include "plc_consts.svh"
`default_nettype none

module plc_ctrl
	import plc_pkg::*;
#(
	parameter int SOFTSTART_CYCLES = `PLC_SOFTSTART_CYC,
	parameter logic [32:0] TEST_PERIOD_CYCLES = 33'(`PLC_TEST_PERIOD_CYC)
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic enable_above_low,
	input wire logic enable_above_high,
	input wire logic input_above_lockout_level,
	input wire logic input_overvoltage,
	input wire logic input_undervoltage,
	input wire logic switch_overcurrent,
	input wire logic switch_current_warning,
	input wire logic drop_above_560mv,
	input wire logic drop_below_200mv,
	input wire logic storage_node_below_3v6,
	input wire logic storage_node_overvoltage,
	input wire logic storage_node_undervoltage,
	input wire logic buck_output_fault,
	input wire logic buck_undervoltage,
	input wire logic temp_above_145c,
	input wire logic temp_above_155c,
	input wire logic regulator_fail,
	input wire logic boot_cap_fail,
	input wire logic reference_undervoltage,
	input wire logic monitor_data_ready,
	input wire logic monitor_limit,
	input wire logic capacitor_test_done,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic [2:0] enable_high_threshold,
	input wire logic [`PLC_STATUS_W-1:0] alert_mask,
	input wire logic ctrl_write,
	input wire logic [7:0] ctrl_wdata,
	input wire logic status_read,
	output logic [2:0] state_code,
	output logic switch_on,
	output logic boost_on,
	output logic buck_on,
	output logic monitor_on,
	output logic reference_on,
	output logic i2c_on,
	output logic [10:0] enable_high_mv,
	output logic [7:0] ctrl_rdata,
	output logic [`PLC_STATUS_W-1:0] fault_status,
	output logic fault_alert_n,
	output logic i2c_packet_restart
);

	// ------------------------------------------------------------
	// decode functions
	// ------------------------------------------------------------
	// fixed code of each state for the state field
	function automatic plc_code_t code_of(input plc_state_e s);
		case (s)
			st_hold: code_of = `PLC_CODE_HOLD;
			st_soft: code_of = `PLC_CODE_SOFT;
			st_normal: code_of = `PLC_CODE_NORMAL;
			st_test: code_of = `PLC_CODE_TEST;
			st_supply: code_of = `PLC_CODE_SUPPLY;
			st_warn: code_of = `PLC_CODE_WARN;
			st_full: code_of = `PLC_CODE_FULL;
			default: code_of = `PLC_CODE_HOLD;
		endcase
	endfunction

	// enables {switch, boost, buck, monitor, reference, i2c} per state
	function automatic logic [5:0] enables_of(input plc_state_e s);
		case (s)
			st_hold: enables_of = 6'h00;
			st_soft: enables_of = 6'h23;
			st_normal: enables_of = 6'h37;
			st_test: enables_of = 6'h37;
			st_supply: enables_of = 6'h0F;
			st_warn: enables_of = 6'h23 | 6'h04;
			st_full: enables_of = 6'h00;
			default: enables_of = 6'h00;
		endcase
	endfunction

	// millivolts of the enable high threshold code
	function automatic logic [10:0] mv_of(input logic [2:0] c);
		case (c)
			3'h1: mv_of = `PLC_ENOV_MV_1;
			3'h2: mv_of = `PLC_ENOV_MV_2;
			3'h3: mv_of = `PLC_ENOV_MV_3;
			3'h4: mv_of = `PLC_ENOV_MV_4;
			3'h5: mv_of = `PLC_ENOV_MV_5;
			3'h6: mv_of = `PLC_ENOV_MV_6;
			3'h7: mv_of = `PLC_ENOV_MV_7;
			default: mv_of = `PLC_ENOV_MV_0;
		endcase
	endfunction

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [`PLC_SYNC_W-1:0] raw_in;
	logic [`PLC_SYNC_W-1:0] sync1_reg;
	logic [`PLC_SYNC_W-1:0] sync2_reg;
	logic s_en_low, s_en_high, s_lockout, s_in_ov, s_in_uv, s_oc, s_cur_warn;
	logic s_drop_hi, s_drop_lo, s_stor_low, s_stor_ov, s_stor_uv, s_buck_fault;
	logic s_buck_uv, s_t145, s_t155, s_reg_fail, s_boot_fail, s_ref_uv;
	logic s_mon_ready, s_mon_limit, s_test_done, s_scl, s_sda;

	assign raw_in = {enable_above_low, enable_above_high, input_above_lockout_level,
		input_overvoltage, input_undervoltage, switch_overcurrent, switch_current_warning,
		drop_above_560mv, drop_below_200mv, storage_node_below_3v6, storage_node_overvoltage,
		storage_node_undervoltage, buck_output_fault, buck_undervoltage, temp_above_145c,
		temp_above_155c, regulator_fail, boot_cap_fail, reference_undervoltage,
		monitor_data_ready, monitor_limit, capacitor_test_done, scl_in, sda_in};

	// two flops per pin, first read only by the second
	genvar gi;
	generate
		for (gi = 0; gi < `PLC_SYNC_W; gi++) begin : g_sync
			always_ff @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end else begin
					sync1_reg[gi] <= raw_in[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	assign {s_en_low, s_en_high, s_lockout, s_in_ov, s_in_uv, s_oc, s_cur_warn,
		s_drop_hi, s_drop_lo, s_stor_low, s_stor_ov, s_stor_uv, s_buck_fault,
		s_buck_uv, s_t145, s_t155, s_reg_fail, s_boot_fail, s_ref_uv,
		s_mon_ready, s_mon_limit, s_test_done, s_scl, s_sda} = sync2_reg;

	// ------------------------------------------------------------
	// condition decode
	// ------------------------------------------------------------
	logic en_over;
	logic supply_fault;
	logic warn_cond;
	logic backup_exit;
	logic full_exit;
	logic ctrl_take;
	logic force_req;
	logic test_set;

	// code zero turns high detection off
	assign en_over = s_en_high && (enable_high_threshold != `PLC_ENOV_OFF);
	assign supply_fault = !s_en_low || en_over || s_in_ov || s_oc || s_drop_hi;
	assign warn_cond = s_t145 || s_reg_fail || s_boot_fail;
	assign backup_exit = !s_en_low || s_stor_low || s_buck_fault;
	assign full_exit = !s_t155 && !s_oc;
	// register writes only land while the port is alive
	assign ctrl_take = ctrl_write && i2c_on;
	assign force_req = ctrl_take && ctrl_wdata[`PLC_CTRL_FORCE_OFF_BIT];
	assign test_set = ctrl_take && ctrl_wdata[`PLC_CTRL_TEST_BIT];

	// ------------------------------------------------------------
	// timers
	// ------------------------------------------------------------
	plc_state_e state_reg;
	plc_state_e state_next;
	logic [31:0] soft_cnt_reg;
	logic [32:0] per_cnt_reg;
	logic soft_done;
	logic per_done;
	logic test_bit_reg;

	assign soft_done = soft_cnt_reg == 32'(SOFTSTART_CYCLES);
	assign per_done = per_cnt_reg == (TEST_PERIOD_CYCLES - 33'h1);

	// soft-start timer saturates, periodic test timer runs in normal only
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			soft_cnt_reg <= 32'h0;
			per_cnt_reg <= 33'h0;
		end else begin
			soft_cnt_reg <= (state_reg != st_soft) ? 32'h0 :
				(soft_done ? soft_cnt_reg : soft_cnt_reg + 32'h1);
			per_cnt_reg <= (state_reg != st_normal || per_done) ? 33'h0 :
				per_cnt_reg + 33'h1;
		end
	end

	// manual test request bit, a new write wins over the finish clear
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			test_bit_reg <= 1'b0;
		end else if (test_set) begin
			test_bit_reg <= 1'b1;
		end else if (state_reg == st_test && s_test_done) begin
			test_bit_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// state machine
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			st_hold: begin
				if (s_en_low && s_lockout) state_next = st_soft;
			end
			st_soft: begin
				if (force_req) state_next = st_hold;
				else if (warn_cond) state_next = st_warn;
				else if (s_drop_lo && soft_done) state_next = st_normal;
			end
			st_normal: begin
				if (force_req) state_next = st_hold;
				else if (supply_fault) state_next = st_supply;
				else if (warn_cond) state_next = st_warn;
				else if (per_done || test_bit_reg) state_next = st_test;
			end
			st_test: begin
				if (force_req) state_next = st_hold;
				else if (supply_fault) state_next = st_supply;
				else if (warn_cond) state_next = st_warn;
				else if (s_test_done) state_next = st_normal;
			end
			st_supply: begin
				if (force_req || backup_exit) state_next = st_hold;
			end
			st_warn: begin
				if (force_req) state_next = st_hold;
				else if (s_t155) state_next = st_full;
				else if (!warn_cond) state_next = st_normal;
			end
			st_full: begin
				if (full_exit) state_next = st_soft;
			end
			default: state_next = st_hold;
		endcase
	end

	// power-up lands in hold; settings live outside and are not cleared here
	logic [5:0] enables_reg;
	logic [2:0] code_reg;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_reg <= st_hold;
			enables_reg <= 6'h00;
			code_reg <= `PLC_CODE_HOLD;
		end else begin
			state_reg <= state_next;
			enables_reg <= enables_of(state_next);
			code_reg <= code_of(state_next);
		end
	end

	assign {switch_on, boost_on, buck_on, monitor_on, reference_on, i2c_on} = enables_reg;
	assign state_code = code_reg;

	// ------------------------------------------------------------
	// settings and register views
	// ------------------------------------------------------------
	logic [10:0] mv_reg;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			mv_reg <= `PLC_ENOV_MV_0;
		end else begin
			mv_reg <= mv_of(enable_high_threshold);
		end
	end

	assign enable_high_mv = mv_reg;
	// force bit reads as zero, test bit shows pending request
	assign ctrl_rdata = {6'h00, test_bit_reg, 1'b0};

	// ------------------------------------------------------------
	// i2c start condition restart
	// ------------------------------------------------------------
	logic sda_prev_reg;
	logic start_seen;
	logic restart_reg;
	assign start_seen = s_scl && sda_prev_reg && !s_sda;

	// start condition or hold entry resets the packet engine
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sda_prev_reg <= 1'b1;
			restart_reg <= 1'b0;
		end else begin
			sda_prev_reg <= s_sda;
			restart_reg <= start_seen || (state_next == st_hold && state_reg != st_hold);
		end
	end

	assign i2c_packet_restart = restart_reg;

	// ------------------------------------------------------------
	// alert
	// ------------------------------------------------------------
	logic [`PLC_STATUS_W-1:0] status_vec;
	assign status_vec = {s_in_ov, s_in_uv, s_t145, s_t155, s_drop_hi, s_cur_warn, s_oc,
		s_stor_ov, s_stor_uv, state_reg == st_supply, s_buck_fault, s_buck_uv, s_ref_uv,
		s_mon_ready, s_mon_limit};

	plc_alert #(
		.N(`PLC_STATUS_W)
	) u_alert (
		.clk_sys(clk_sys),
		.reset(reset),
		.status_in(status_vec),
		.alert_mask(alert_mask),
		.status_read(status_read),
		.fault_status(fault_status),
		.fault_alert_n(fault_alert_n)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	soft_exit_timer_a: assert property (@(posedge clk_sys) disable iff (reset)
		(state_reg == st_normal && $past(state_reg) == st_soft) |-> $past(soft_done))
		else $error("soft-start left before timer expired");

	force_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
		(force_req && state_reg != st_hold) |=> state_reg == st_hold)
		else $error("force power off did not reach hold");

	hold_exit_a: assert property (@(posedge clk_sys) disable iff (reset)
		(state_reg == st_hold && s_en_low && s_lockout) |=> state_reg == st_soft ##1 switch_on)
		else $error("hold did not advance to soft-start");

	test_fault_a: assert property (@(posedge clk_sys) disable iff (reset)
		(state_reg == st_test && supply_fault && !force_req) |=> state_reg == st_supply)
		else $error("fault in test did not enter backup");

	backup_enables_a: assert property (@(posedge clk_sys) disable iff (reset)
		(state_reg == st_supply) |-> (buck_on && !switch_on && !boost_on))
		else $error("backup enables wrong");

	test_bit_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
		(state_reg == st_test && s_test_done && !test_set) |=> !test_bit_reg)
		else $error("test request bit not cleared at finish");

	full_off_a: assert property (@(posedge clk_sys) disable iff (reset)
		(state_reg == st_full) |-> (!switch_on && !i2c_on && !reference_on && !monitor_on))
		else $error("function alive in full shutdown");

	warn_enables_a: assert property (@(posedge clk_sys) disable iff (reset)
		(state_reg == st_warn) |-> (switch_on && monitor_on && i2c_on && !boost_on))
		else $error("warning shutdown enables wrong");

	i2c_restart_a: assert property (@(posedge clk_sys) disable iff (reset)
		start_seen |=> i2c_packet_restart)
		else $error("start condition did not restart packet engine");

	state_code_a: assert property (@(posedge clk_sys) disable iff (reset)
		(state_reg == st_test) |-> state_code == `PLC_CODE_TEST)
		else $error("state field does not show test code");

endmodule

`default_nettype wire

// ==== plc_host_model.sv ====
// host-side model: status reads after the alert, i2c frames on the pins
`default_nettype none

module plc_host_model (
	input wire logic clk_sys,
	input wire logic fault_alert_n,
	input wire logic read_en,
	input wire logic [3:0] read_lag,
	input wire logic frame_go,
	output logic status_read,
	output logic scl_in,
	output logic sda_in
);
	timeunit 1ns;
	timeprecision 1ns;

	int lag = 0;

	// read status some cycles after the alert falls, again while it stays low
	always @(negedge clk_sys) begin
		lag = (read_en && fault_alert_n === 1'b0) ? lag + 1 : 0;
		status_read <= (lag > read_lag);
		if (lag > read_lag) begin
			lag = 0;
		end
	end

	// lines idle high by pull-up, clock stands still outside frames
	// frame: start, one clock, repeated start, one clock, stop; 320 ns clock
	initial begin
		scl_in = 1'b1;
		sda_in = 1'b1;
		forever begin
			@(posedge frame_go);
			repeat (2) begin
				#80 sda_in = 1'b0;
				#80 scl_in = 1'b0;
				#160 scl_in = 1'b1;
				#160 scl_in = 1'b0;
				#80 sda_in = 1'b1;
				#80 scl_in = 1'b1;
			end
			// stop: data rises only while the clock is high
			#80 scl_in = 1'b0;
			#80 sda_in = 1'b0;
			#80 scl_in = 1'b1;
			#80 sda_in = 1'b1;
		end
	end
endmodule

`default_nettype wire

// ==== test_plc_ctrl.sv ====
// testbench of the power loss state controller
`include "plc_consts.svh"
`default_nettype none

module test_plc_ctrl;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [2:0] c_hold = `PLC_CODE_HOLD;
	localparam logic [2:0] c_soft = `PLC_CODE_SOFT;
	localparam logic [2:0] c_norm = `PLC_CODE_NORMAL;
	localparam logic [2:0] c_test = `PLC_CODE_TEST;
	localparam logic [2:0] c_supp = `PLC_CODE_SUPPLY;
	localparam logic [2:0] c_warn = `PLC_CODE_WARN;
	localparam logic [2:0] c_full = `PLC_CODE_FULL;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [21:0] pin = 22'h0;
	logic [2:0] thr = 3'h0;
	logic [14:0] mask = 15'h0000;
	logic wr_en = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic read_en = 1'b0;
	logic [3:0] read_lag = 4'h2;
	logic frame_go = 1'b0;
	logic status_read, scl_in, sda_in, fault_alert_n, restart;
	logic switch_on, boost_on, buck_on, monitor_on, reference_on, i2c_on;
	logic [2:0] state_code;
	logic [10:0] mv;
	logic [7:0] rdata;
	logic [14:0] fstat;
	int bad_count = 0;
	int checked = 0;
	int restarts = 0;
	logic [31:0] seed = 32'h00000040;
	// expected enables {switch,boost,buck,monitor,ref,i2c} per state code
	logic [5:0] en_tab [7] = '{6'h00, 6'h23, 6'h37, 6'h37, 6'h0F, 6'h27, 6'h00};
	int mv_tab [8] = '{0, 820, 920, 1000, 1080, 1160, 1240, 1320};
	int src [5] = '{0, 1, 3, 5, 7};
	int wsrc [3] = '{14, 16, 17};

	always #20 clk_sys = ~clk_sys;
	// count restart pulses where they are settled
	always @(negedge clk_sys) begin
		if (restart === 1'b1) begin
			restarts++;
		end
	end

	plc_ctrl #(.SOFTSTART_CYCLES(20), .TEST_PERIOD_CYCLES(33'hBB8)) i_dut (
		.clk_sys(clk_sys), .reset(reset), .enable_above_low(pin[0]),
		.enable_above_high(pin[1]), .input_above_lockout_level(pin[2]),
		.input_overvoltage(pin[3]), .input_undervoltage(pin[4]),
		.switch_overcurrent(pin[5]), .switch_current_warning(pin[6]),
		.drop_above_560mv(pin[7]), .drop_below_200mv(pin[8]),
		.storage_node_below_3v6(pin[9]), .storage_node_overvoltage(pin[10]),
		.storage_node_undervoltage(pin[11]), .buck_output_fault(pin[12]),
		.buck_undervoltage(pin[13]), .temp_above_145c(pin[14]), .temp_above_155c(pin[15]),
		.regulator_fail(pin[16]), .boot_cap_fail(pin[17]), .reference_undervoltage(pin[18]),
		.monitor_data_ready(pin[19]), .monitor_limit(pin[20]), .capacitor_test_done(pin[21]),
		.scl_in(scl_in), .sda_in(sda_in), .enable_high_threshold(thr), .alert_mask(mask),
		.ctrl_write(wr_en), .ctrl_wdata(wdata), .status_read(status_read),
		.state_code(state_code), .switch_on(switch_on), .boost_on(boost_on),
		.buck_on(buck_on), .monitor_on(monitor_on), .reference_on(reference_on),
		.i2c_on(i2c_on), .enable_high_mv(mv), .ctrl_rdata(rdata), .fault_status(fstat),
		.fault_alert_n(fault_alert_n), .i2c_packet_restart(restart));

	plc_host_model i_host (.clk_sys(clk_sys), .fault_alert_n(fault_alert_n),
		.read_en(read_en), .read_lag(read_lag), .frame_go(frame_go),
		.status_read(status_read), .scl_in(scl_in), .sda_in(sda_in));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xrand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic stop_test();
		$display("bad_count %0d checked %0d", bad_count, checked);
		if (bad_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// wait for a state, then compare the function enables
	task automatic go(input logic [2:0] code);
		int n;
		n = 0;
		while (state_code !== code && n < 4000) begin
			@(negedge clk_sys);
			n++;
		end
		if (state_code !== code) begin
			bad_count++;
			$display("BAD %0t state %0d not reached", $time, code);
			stop_test();
		end else begin
			check(16'({switch_on, boost_on, buck_on, monitor_on, reference_on, i2c_on}),
				16'(en_tab[code]));
		end
	endtask

	// read-modify-write keeps the fields not being set
	task automatic wr(input logic [7:0] d);
		wdata = rdata | d;
		wr_en = 1'b1;
		cyc(1);
		wr_en = 1'b0;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		cyc(10);
		check(16'({state_code, switch_on, boost_on, buck_on, monitor_on, reference_on, i2c_on,
			fault_alert_n}), 16'h0001);
		reset = 1'b0;
		pin[0] = 1'b1;
		pin[8] = 1'b1;
		cyc(10);
		check(16'(state_code), 16'(c_hold));
		pin[2] = 1'b1;
		go(c_soft);
		cyc(12);
		check(16'(state_code), 16'(c_soft));
		go(c_norm);
		for (int i = 0; i < 8; i++) begin
			thr = 3'(i);
			cyc(2);
			check(16'(mv), 16'(mv_tab[i]));
		end
		pin[19] = 1'b1;
		cyc(6);
		check({fstat, fault_alert_n}, 16'h0004);
		read_lag = 4'(xrand());
		read_en = 1'b1;
		cyc(30);
		check(16'(fault_alert_n), 16'h0000);
		pin[19] = 1'b0;
		cyc(30);
		check(16'(fault_alert_n), 16'h0001);
		mask = 15'h0001;
		pin[20] = 1'b1;
		cyc(8);
		check({fstat, fault_alert_n}, 16'h0003);
		pin[20] = 1'b0;
		cyc(8);
		mask = 15'h0000;
		wr(8'h02);
		go(c_test);
		check(16'(rdata), 16'h0002);
		cyc(32'(xrand() % 8));
		pin[21] = 1'b1;
		go(c_norm);
		pin[21] = 1'b0;
		check(16'(rdata), 16'h0000);
		go(c_test);
		pin[21] = 1'b1;
		go(c_norm);
		pin[21] = 1'b0;
		restarts = 0;
		frame_go = 1'b1;
		cyc(60);
		frame_go = 1'b0;
		check(16'(restarts), 16'h0002);
		for (int i = 0; i < 3; i++) begin
			pin[wsrc[i]] = 1'b1;
			go(c_warn);
			pin[wsrc[i]] = 1'b0;
			go(c_norm);
		end
		pin[14] = 1'b1;
		go(c_warn);
		pin[15] = 1'b1;
		go(c_full);
		wr(8'h02);
		pin[15:14] = 2'h0;
		go(c_soft);
		go(c_norm);
		check(16'(rdata), 16'h0000);
		thr = 3'h3;
		for (int k = 0; k < 5; k++) begin
			int ex;
			ex = xrand() % 2 ? 9 : 12;
			if (k == 4) begin
				wr(8'h02);
				go(c_test);
			end
			pin[src[k]] = ~pin[src[k]];
			go(c_supp);
			pin[ex] = 1'b1;
			go(c_hold);
			pin[ex] = 1'b0;
			pin[src[k]] = (k == 0);
			go(c_soft);
			go(c_norm);
		end
		check(16'(rdata), 16'h0002);
		go(c_test);
		pin[21] = 1'b1;
		go(c_norm);
		pin[21] = 1'b0;
		thr = 3'h0;
		pin[1] = 1'b1;
		cyc(8);
		check(16'(state_code), 16'(c_norm));
		pin[1] = 1'b0;
		wr(8'h01);
		go(c_hold);
		go(c_soft);
		stop_test();
	end
endmodule

`default_nettype wire
